// [bench/plb_line_partner.sv]
// line partner: cable echo of transmit bytes, or a counting source
`timescale 1ns/10ps
`default_nettype none
module plb_line_partner (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [7:0] line_tx_data,
    input wire logic line_tx_valid,
    input wire logic send,
    input wire logic corrupt,
    output logic [7:0] line_rx_data,
    output logic line_rx_valid
);
    logic [7:0] cnt;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt <= 8'h00;
            line_rx_valid <= 1'b0;
            line_rx_data <= 8'h00;
        end
        else
        begin
            cnt <= cnt + 8'h01;
            line_rx_valid <= send || line_tx_valid;
            if (send)
                line_rx_data <= cnt;
            else if (line_tx_valid)
                line_rx_data <= line_tx_data ^ {7'h00, corrupt};
            else
                line_rx_data <= ~line_rx_data; // idle line inverts the last byte every cycle
        end
    end
endmodule
`default_nettype wire

// [bench/plb_monitor.sv]
// port-level assertion checker for the self-test block
`timescale 1ns/10ps
`default_nettype none
module plb_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [1:0] hresp,
    input wire logic [31:0] hrdata,
    input wire logic [7:0] line_rx_data,
    input wire logic line_rx_valid,
    input wire logic [7:0] mac_rx_data,
    input wire logic mac_rx_valid,
    input wire logic speed_100,
    input wire logic speed_1000,
    input wire logic loop_digital,
    input wire logic loop_analog,
    input wire logic loop_external,
    input wire logic loop_reverse,
    input wire logic loop_pcs_before_scrambler,
    input wire logic loop_pcs_after_scrambler,
    input wire logic loop_pcs_after_mlt3,
    input wire logic loop_pcs_gigabit,
    input wire logic leader_legacy_coding,
    input wire logic follower_legacy_coding,
    input wire logic core_sleeping
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic rd_st;
    logic [3:0] lp;
    logic [2:0] lp100;
    assign rd_st = hsel && htrans[1] && hready && !hwrite
        && hsize == plb_pkg::HSIZE_WORD && haddr == 32'h0000_005c;
    assign lp = {loop_reverse, loop_external, loop_analog, loop_digital};
    assign lp100 = {loop_pcs_after_mlt3, loop_pcs_after_scrambler,
        loop_pcs_before_scrambler};
    AST_BUS_OKAY: assert property (hreadyout && hresp == plb_pkg::HRESP_OKAY)
        else $error("slave not ready or response not okay");
    AST_SEL_ONEHOT: assert property ($onehot0(lp))
        else $error("more than one loop point active");
    AST_PCS_WINS: assert property (
        |{lp100, loop_pcs_gigabit} |-> !(|lp))
        else $error("selector loop beside pcs loop");
    AST_PCS_100: assert property (
        |lp100 |-> speed_100 && $onehot(lp100))
        else $error("bad 100M pcs loop point");
    AST_PCS_1G: assert property (loop_pcs_gigabit |-> speed_1000)
        else $error("gigabit loop outside 1000M");
    AST_RX_FOLLOWS: assert property (mac_rx_valid |->
        $past(line_rx_valid) && mac_rx_data == $past(line_rx_data))
        else $error("mac receive byte not from line");
    AST_POWER_READ: assert property (
        rd_st && $stable(core_sleeping) |=>
        hrdata[plb_pkg::POWER_BIT] == !$past(core_sleeping, 2))
        else $error("power bit wrong");
    AST_LEADER_READ: assert property (rd_st |=>
        hrdata[plb_pkg::LEADER_BIT] == $past(leader_legacy_coding))
        else $error("leader bit wrong");
    AST_FOLLOWER_READ: assert property (rd_st |=>
        hrdata[plb_pkg::FOLLOWER_BIT] == $past(follower_legacy_coding))
        else $error("follower bit wrong");
endmodule
bind plb_top plb_monitor u_mon (.*);
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench: register access, loop control, pattern and status
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam logic [31:0] A_CTRL = {22'h0, plb_pkg::CTRL_IDX, 2'h0};
    localparam logic [31:0] A_STAT = {22'h0, plb_pkg::STATUS_IDX, 2'h0};
    localparam logic [31:0] A_IRQ = {22'h0, plb_pkg::IRQ_STATUS_IDX, 2'h0};
    localparam logic [31:0] A_MSK = {22'h0, plb_pkg::IRQ_MASK_IDX, 2'h0};
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, irq, send, corrupt;
    logic mac_tx_valid, line_tx_valid, line_rx_valid, mac_rx_valid;
    logic speed_100, speed_1000, leader_legacy_coding, follower_legacy_coding;
    logic core_sleeping, powered_device_found, detect_no_signal;
    logic detect_watchdog_expired, non_powered_device_found;
    logic loop_digital, loop_analog, loop_external, loop_reverse;
    logic loop_pcs_before_scrambler, loop_pcs_after_scrambler;
    logic loop_pcs_after_mlt3, loop_pcs_gigabit;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, hresp;
    logic [2:0] hsize;
    logic [7:0] mac_tx_data, line_tx_data, line_rx_data, mac_rx_data, lp;
    logic [3:0] pd_ev;
    logic [3:0] sels [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h0};
    int miscompares, tests_run;
    assign hready = hreadyout;
    assign {powered_device_found, detect_no_signal, detect_watchdog_expired,
        non_powered_device_found} = pd_ev;
    assign lp = {loop_pcs_gigabit, loop_pcs_after_mlt3,
        loop_pcs_after_scrambler, loop_pcs_before_scrambler,
        loop_reverse, loop_external, loop_analog, loop_digital};
    plb_top #(.LOCK_MATCHES(4)) u_dut (.*);
    plb_line_partner u_partner (.*);
    initial
    begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        if (miscompares == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                miscompares++;
                test_done();
            end
            @(posedge hclk);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        @(posedge hclk);
    endtask
    task automatic rchk(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask
    initial
    begin
        miscompares = 0;
        tests_run = 0;
        {hresetn, hsel, hwrite, mac_tx_valid, send, corrupt} = 6'h00;
        {speed_1000, leader_legacy_coding, follower_legacy_coding} = 3'h0;
        speed_100 = 1'b1;
        core_sleeping = 1'b0;
        {haddr, hwdata} = 64'h0;
        htrans = 2'h0;
        hsize = plb_pkg::HSIZE_WORD;
        mac_tx_data = 8'h00;
        pd_ev = 4'h0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(A_CTRL, 32'h0000_0000);
        rchk(A_STAT, 32'h0000_0040);
        wr(32'h0000_0060, 32'h0000_ffff);
        rchk(32'h0000_0060, 32'h0000_0000);
        rchk(A_CTRL, 32'h0000_0000);
        wr(A_CTRL, 32'h0000_0fff);
        rchk(A_CTRL, 32'h0000_037f);
        foreach (sels[i])
        begin
            wr(A_CTRL, {26'h0, sels[i], 2'h0});
            chk({24'h0, lp},
                {28'h0, $onehot0(sels[i]) ? sels[i] : 4'h0});
        end
        wr(A_CTRL, 32'h0000_0021);
        chk({24'h0, lp}, 32'h0000_0010);
        for (int p = 1; p < 4; p++)
        begin
            wr(A_CTRL, p);
            chk({24'h0, lp}, 32'h0000_0008 << p);
        end
        speed_100 <= 1'b0;
        speed_1000 <= 1'b1;
        for (int p = 1; p < 4; p++)
        begin
            wr(A_CTRL, p);
            chk({24'h0, lp},
                p[0] ? 32'h0000_0080 : 32'h0000_0000);
        end
        speed_100 <= 1'b1;
        speed_1000 <= 1'b0;
        wr(A_CTRL, 32'h0000_00a0);
        rchk(A_CTRL, 32'h0000_00a0);
        send <= 1'b1;
        repeat (3) @(posedge hclk);
        chk({31'h0, mac_rx_valid}, 32'h0000_0001);
        wr(A_CTRL, 32'h0000_0020);
        repeat (3) @(posedge hclk);
        chk({31'h0, mac_rx_valid}, 32'h0000_0000);
        wr(A_CTRL, 32'h0000_0080);
        send <= 1'b0;
        rchk(A_CTRL, 32'h0000_0000);
        mac_tx_valid <= 1'b1;
        mac_tx_data <= 8'h5a;
        wr(A_CTRL, 32'h0000_0001);
        @(posedge hclk);
        chk({31'h0, line_tx_valid}, 32'h0000_0000);
        wr(A_CTRL, 32'h0000_0041);
        @(posedge hclk);
        chk({23'h0, line_tx_valid, line_tx_data}, 32'h0000_015a);
        mac_tx_valid <= 1'b0;
        wr(A_CTRL, 32'h0000_0000);
        leader_legacy_coding <= 1'b1;
        core_sleeping <= 1'b1;
        @(posedge hclk);
        rchk(A_STAT, 32'h0000_0100);
        leader_legacy_coding <= 1'b0;
        follower_legacy_coding <= 1'b1;
        core_sleeping <= 1'b0;
        @(posedge hclk);
        rchk(A_STAT, 32'h0000_00c0);
        follower_legacy_coding <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            pd_ev <= 4'h1 << i;
            @(posedge hclk);
            pd_ev <= 4'h0;
            rchk(A_STAT, 32'h0000_0040 | (32'h0000_1000 << i));
            rchk(A_STAT, 32'h0000_0040);
        end
        rchk(A_IRQ, 32'h0000_000f);
        wr(A_MSK, 32'h0000_0004);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(A_IRQ, 32'h0000_0004);
        chk({31'h0, irq}, 32'h0000_0000);
        rchk(A_IRQ, 32'h0000_000b);
        wr(A_IRQ, 32'h0000_000b);
        wr(A_CTRL, 32'h0000_5000);
        repeat (3) @(posedge hclk);
        rchk(A_STAT, 32'h0000_0040);
        wr(A_CTRL, 32'h0000_f000);
        repeat (20) @(posedge hclk);
        rchk(A_STAT, 32'h0000_0a40);
        corrupt <= 1'b1;
        @(posedge hclk);
        corrupt <= 1'b0;
        repeat (6) @(posedge hclk);
        bus(1'b0, A_STAT, 32'h0000_0000);
        chk(rd & 32'h0000_0400, 32'h0000_0400);
        repeat (20) @(posedge hclk);
        rchk(A_STAT, 32'h0000_0a40);
        wr(A_MSK, 32'h0000_0010);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(A_IRQ, 32'h0000_0010);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(A_CTRL, 32'h0000_0000);
        repeat (3) @(posedge hclk);
        bus(1'b0, A_STAT, 32'h0000_0000);
        chk(rd & 32'h0000_0200, 32'h0000_0000);
        test_done();
    end
endmodule
`default_nettype wire

// [src/plb_pkg.sv]
// constants, types and pattern function shared by the self-test block
// Operation
// (RULE_01) generator field: zero off, all ones continuous
// (RULE_02) reverse receive forward bit only in reverse loop
// (RULE_03) mii transmit forward bit only in mii loop
// (RULE_04) selector: none, digital, analog, external, reverse
// (RULE_05) selector acts only while pcs select zero
// (RULE_06) 100M pcs select: scrambler and mlt3 loop points
// (RULE_07) 1000M pcs select low bit: gigabit loop
// (RULE_08) locked bit follows checker synchronisation
// (RULE_09) sync lost latches high, clears on read
// (RULE_10) generator active bit while generator produces
// (RULE_11) leader legacy coding status bit
// (RULE_12) follower legacy coding status bit
// (RULE_13) power bit resets one, zero when asleep
// (RULE_14) powered device found, clear on read
// (RULE_15) detection saw no signal, clear on read
// (RULE_16) detection watchdog expired, clear on read
// (RULE_17) non powered device found, clear on read
// (RULE_18) forward bits stay clear outside their mode
package plb_pkg;
    localparam logic [7:0] CTRL_IDX = 8'h16;
    localparam logic [7:0] STATUS_IDX = 8'h17;
    localparam logic [7:0] IRQ_STATUS_IDX = 8'h20;
    localparam logic [7:0] IRQ_MASK_IDX = 8'h21;
    localparam int ADDR_LSB = 2;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] STATUS_RESET = 16'h0040;
    localparam logic [15:0] CTRL_WMASK = 16'hf3ff;
    localparam int GEN_LSB = 12;
    localparam logic [3:0] GEN_OFF = 4'h0;
    localparam logic [3:0] GEN_CONT = 4'hf;
    localparam int REV_FWD_BIT = 7;
    localparam int MII_FWD_BIT = 6;
    localparam int SEL_LSB = 2;
    localparam logic [3:0] SEL_NONE = 4'h0;
    localparam logic [3:0] SEL_DIGITAL = 4'h1;
    localparam logic [3:0] SEL_ANALOG = 4'h2;
    localparam logic [3:0] SEL_EXTERNAL = 4'h4;
    localparam logic [3:0] SEL_REVERSE = 4'h8;
    localparam int PCS_LSB = 0;
    localparam logic [1:0] PCS_OFF = 2'h0;
    localparam logic [1:0] PCS_BEFORE_SCR = 2'h1;
    localparam logic [1:0] PCS_AFTER_SCR = 2'h2;
    localparam logic [1:0] PCS_AFTER_MLT3 = 2'h3;
    localparam int PD_FOUND_BIT = 15;
    localparam int LOCKED_BIT = 11;
    localparam int LOST_BIT = 10;
    localparam int ACTIVE_BIT = 9;
    localparam int LEADER_BIT = 8;
    localparam int FOLLOWER_BIT = 7;
    localparam int POWER_BIT = 6;
    localparam int IRQ_W = 5;
    localparam int IRQ_LOST_BIT = 4;
    localparam logic [6:0] PRBS_SEED = 7'h7f;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    typedef enum logic {PLB_HUNT = 1'b0, PLB_LOCK = 1'b1} plb_chk_state_t;

    // prbs7 (x^7 + x^6 + 1), eight bits msb first; next seed is byte[6:0]
    function automatic logic [7:0] plb_prbs7_byte(input logic [6:0] seed);
        logic [6:0] s;
        logic [7:0] b;
        s = seed;
        b = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            b = {b[6:0], s[6] ^ s[5]};
            s = {s[5:0], s[6] ^ s[5]};
        end
        return b;
    endfunction
endpackage

// [src/plb_prbs_chk.sv]
// self-synchronising prbs7 checker with lock and loss detection
`timescale 1ns/10ps
`default_nettype none
module plb_prbs_chk #(
    parameter int LOCK_MATCHES = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    output logic locked,
    output logic sync_lost
);
    localparam int CW = $clog2(LOCK_MATCHES + 1);
    localparam logic [CW-1:0] LOCK_COUNT = CW'(LOCK_MATCHES);

    typedef struct packed {
        plb_pkg::plb_chk_state_t state;
        logic [7:0] prev;
        logic [CW-1:0] count;
        logic lost;
    } plb_chk_t;

    plb_chk_t r;
    plb_chk_t next_r;
    logic match;

    // an all-zero stream also predicts itself; the generator never sends it
    assign match = rx_data == plb_pkg::plb_prbs7_byte(r.prev[6:0]);

    always_comb
    begin
        next_r = r;
        next_r.lost = 1'b0;
        if (rx_valid)
        begin
            next_r.prev = rx_data;
            unique case (r.state)
                plb_pkg::PLB_HUNT:
                begin
                    next_r.count = match ? r.count + CW'(1) : '0;
                    if (match && r.count == LOCK_COUNT - CW'(1))
                    begin
                        next_r.state = plb_pkg::PLB_LOCK; // RULE_08
                        next_r.count = '0;
                    end
                end
                plb_pkg::PLB_LOCK:
                begin
                    if (!match)
                    begin
                        next_r.state = plb_pkg::PLB_HUNT; // RULE_08
                        next_r.lost = 1'b1; // RULE_09
                    end
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r <= '{state: plb_pkg::PLB_HUNT, prev: 8'h00, count: '0,
                   lost: 1'b0};
        end
        else
        begin
            r <= next_r;
        end
    end

    assign locked = r.state == plb_pkg::PLB_LOCK;
    assign sync_lost = r.lost;
endmodule
`default_nettype wire

// [src/plb_prbs_gen.sv]
// byte-wide prbs7 pattern generator
`timescale 1ns/10ps
`default_nettype none
module plb_prbs_gen (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic enable,
    output logic [7:0] data,
    output logic valid
);
    typedef struct packed {
        logic [6:0] lfsr;
        logic [7:0] data;
        logic valid;
    } plb_gen_t;

    plb_gen_t r;
    plb_gen_t next_r;

    always_comb
    begin
        next_r = r;
        next_r.valid = enable; // RULE_10
        if (enable)
        begin
            next_r.data = plb_pkg::plb_prbs7_byte(r.lfsr);
            next_r.lfsr = next_r.data[6:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r <= '{lfsr: plb_pkg::PRBS_SEED, data: 8'h00, valid: 1'b0};
        end
        else
        begin
            r <= next_r;
        end
    end

    assign data = r.data;
    assign valid = r.valid;
endmodule
`default_nettype wire

// [src/plb_top.sv]
// self-test, loopback control and general status block with ahb-lite slave
`timescale 1ns/10ps
`default_nettype none
module plb_top #(
    parameter int LOCK_MATCHES = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [1:0] hresp,
    output logic [31:0] hrdata,
    output logic irq,
    input wire logic [7:0] mac_tx_data,
    input wire logic mac_tx_valid,
    output logic [7:0] line_tx_data,
    output logic line_tx_valid,
    input wire logic [7:0] line_rx_data,
    input wire logic line_rx_valid,
    output logic [7:0] mac_rx_data,
    output logic mac_rx_valid,
    input wire logic speed_100,
    input wire logic speed_1000,
    output logic loop_digital,
    output logic loop_analog,
    output logic loop_external,
    output logic loop_reverse,
    output logic loop_pcs_before_scrambler,
    output logic loop_pcs_after_scrambler,
    output logic loop_pcs_after_mlt3,
    output logic loop_pcs_gigabit,
    input wire logic leader_legacy_coding,
    input wire logic follower_legacy_coding,
    input wire logic core_sleeping,
    input wire logic powered_device_found,
    input wire logic detect_no_signal,
    input wire logic detect_watchdog_expired,
    input wire logic non_powered_device_found
);
    typedef struct packed {
        logic [15:0] ctrl;
        logic [3:0] pd_flags;
        logic sync_lost;
        logic core_power_state;
        logic [plb_pkg::IRQ_W-1:0] irq_status;
        logic [plb_pkg::IRQ_W-1:0] irq_mask;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic [31:0] rdata;
        logic [7:0] line_tx_data;
        logic line_tx_valid;
        logic [7:0] mac_rx_data;
        logic mac_rx_valid;
    } plb_state_t;

    plb_state_t r;
    plb_state_t next_r;

    logic take;
    logic mapped;
    logic [7:0] addr_idx;
    logic [3:0] pd_events;
    logic [3:0] gen_ctrl;
    logic [3:0] loop_sel;
    logic [1:0] pcs_sel;
    logic pcs_off;
    logic mii_loop;
    logic gen_on;
    logic [7:0] gen_data;
    logic gen_valid;
    logic checker_locked;
    logic checker_lost_pulse;
    logic [15:0] status_word;

    assign take = hsel && htrans[1] && hready;
    assign addr_idx = haddr[9:2];
    assign mapped = haddr[31:10] == 22'h00_0000 && haddr[1:0] == 2'h0
        && hsize == plb_pkg::HSIZE_WORD;
    assign pd_events = {powered_device_found, detect_no_signal,
        detect_watchdog_expired, non_powered_device_found};

    assign gen_ctrl = r.ctrl[plb_pkg::GEN_LSB +: 4];
    assign loop_sel = r.ctrl[plb_pkg::SEL_LSB +: 4];
    assign pcs_sel = r.ctrl[plb_pkg::PCS_LSB +: 2];
    assign pcs_off = pcs_sel == plb_pkg::PCS_OFF;
    // any pcs loop point counts as mii loopback: data turns inside the pcs
    assign mii_loop = !pcs_off;
    // unsupported generator codes are treated as off
    assign gen_on = gen_ctrl == plb_pkg::GEN_CONT; // RULE_01

    plb_prbs_gen u_gen (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(gen_on),
        .data(gen_data),
        .valid(gen_valid)
    );

    plb_prbs_chk #(
        .LOCK_MATCHES(LOCK_MATCHES)
    ) u_chk (
        .hclk(hclk),
        .hresetn(hresetn),
        .rx_data(line_rx_data),
        .rx_valid(line_rx_valid),
        .locked(checker_locked),
        .sync_lost(checker_lost_pulse)
    );

    always_comb
    begin
        next_r = r;
        status_word = 16'h0000;
        next_r.wr_pend = take && hwrite && mapped;
        next_r.wr_idx = addr_idx;

        // write data phase
        if (r.wr_pend)
        begin
            unique case (r.wr_idx)
                plb_pkg::CTRL_IDX:
                begin
                    next_r.ctrl = hwdata[15:0] & plb_pkg::CTRL_WMASK;
                end
                plb_pkg::IRQ_STATUS_IDX:
                begin
                    next_r.irq_status = r.irq_status
                        & ~hwdata[plb_pkg::IRQ_W-1:0];
                end
                plb_pkg::IRQ_MASK_IDX:
                begin
                    next_r.irq_mask = hwdata[plb_pkg::IRQ_W-1:0];
                end
                default:
                begin
                    next_r.ctrl = next_r.ctrl;
                end
            endcase
        end

        // forward bits are dropped whenever their loop mode is not selected
        if (next_r.ctrl[plb_pkg::SEL_LSB +: 4] != plb_pkg::SEL_REVERSE
            || next_r.ctrl[plb_pkg::PCS_LSB +: 2] != plb_pkg::PCS_OFF)
        begin
            next_r.ctrl[plb_pkg::REV_FWD_BIT] = 1'b0; // RULE_02 RULE_18
        end
        if (next_r.ctrl[plb_pkg::PCS_LSB +: 2] == plb_pkg::PCS_OFF)
        begin
            next_r.ctrl[plb_pkg::MII_FWD_BIT] = 1'b0; // RULE_03 RULE_18
        end

        // status word as seen by a read in this cycle
        status_word[plb_pkg::PD_FOUND_BIT -: 4] = r.pd_flags; // RULE_14
        status_word[plb_pkg::LOCKED_BIT] = checker_locked; // RULE_08
        status_word[plb_pkg::LOST_BIT] = r.sync_lost; // RULE_09
        status_word[plb_pkg::ACTIVE_BIT] = gen_valid; // RULE_10
        status_word[plb_pkg::LEADER_BIT] = leader_legacy_coding; // RULE_11
        status_word[plb_pkg::FOLLOWER_BIT] = follower_legacy_coding; // RULE_12
        status_word[plb_pkg::POWER_BIT] = r.core_power_state; // RULE_13

        // read address phase: data is registered for the data phase
        if (take && !hwrite)
        begin
            next_r.rdata = 32'h0000_0000;
            if (mapped)
            begin
                unique case (addr_idx)
                    plb_pkg::CTRL_IDX:
                    begin
                        next_r.rdata[15:0] = next_r.ctrl;
                    end
                    plb_pkg::STATUS_IDX:
                    begin
                        next_r.rdata[15:0] = status_word;
                        next_r.pd_flags =
                            4'h0; // RULE_14 RULE_15 RULE_16 RULE_17
                        next_r.sync_lost = 1'b0; // RULE_09
                    end
                    plb_pkg::IRQ_STATUS_IDX:
                    begin
                        next_r.rdata[plb_pkg::IRQ_W-1:0] = r.irq_status;
                    end
                    plb_pkg::IRQ_MASK_IDX:
                    begin
                        next_r.rdata[plb_pkg::IRQ_W-1:0] = r.irq_mask;
                    end
                    default:
                    begin
                        next_r.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end

        // events set after any clear so that a coincident event survives
        next_r.pd_flags = next_r.pd_flags
            | pd_events; // RULE_14 RULE_15 RULE_16 RULE_17
        next_r.sync_lost = next_r.sync_lost | checker_lost_pulse; // RULE_09
        next_r.irq_status = next_r.irq_status
            | {checker_lost_pulse, pd_events};
        next_r.core_power_state = !core_sleeping; // RULE_13

        // line transmit path: generator overrides mac data
        if (gen_on || gen_valid)
        begin
            next_r.line_tx_data = gen_data;
            next_r.line_tx_valid = gen_valid;
        end
        else if (mii_loop && !r.ctrl[plb_pkg::MII_FWD_BIT])
        begin
            next_r.line_tx_data = mac_tx_data;
            next_r.line_tx_valid = 1'b0; // RULE_03
        end
        else
        begin
            next_r.line_tx_data = mac_tx_data;
            next_r.line_tx_valid = mac_tx_valid;
        end

        // mac receive path: withheld in reverse loop unless forwarded
        next_r.mac_rx_data = line_rx_data;
        next_r.mac_rx_valid = line_rx_valid
            && !(loop_reverse && !r.ctrl[plb_pkg::REV_FWD_BIT]); // RULE_02
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r <= '{ctrl: plb_pkg::CTRL_RESET,
                   pd_flags: 4'h0,
                   sync_lost: 1'b0,
                   core_power_state: plb_pkg::STATUS_RESET[plb_pkg::POWER_BIT],
                   irq_status: '0,
                   irq_mask: '0,
                   wr_pend: 1'b0,
                   wr_idx: 8'h00,
                   rdata: 32'h0000_0000,
                   line_tx_data: 8'h00,
                   line_tx_valid: 1'b0,
                   mac_rx_data: 8'h00,
                   mac_rx_valid: 1'b0};
        end
        else
        begin
            r <= next_r;
        end
    end

    // loop point decode; selector only when pcs select is zero
    assign loop_digital = pcs_off
        && loop_sel == plb_pkg::SEL_DIGITAL; // RULE_04 RULE_05
    assign loop_analog = pcs_off
        && loop_sel == plb_pkg::SEL_ANALOG; // RULE_04 RULE_05
    assign loop_external = pcs_off
        && loop_sel == plb_pkg::SEL_EXTERNAL; // RULE_04 RULE_05
    assign loop_reverse = pcs_off
        && loop_sel == plb_pkg::SEL_REVERSE; // RULE_04 RULE_05
    assign loop_pcs_before_scrambler = speed_100
        && pcs_sel == plb_pkg::PCS_BEFORE_SCR; // RULE_06
    assign loop_pcs_after_scrambler = speed_100
        && pcs_sel == plb_pkg::PCS_AFTER_SCR; // RULE_06
    assign loop_pcs_after_mlt3 = speed_100
        && pcs_sel == plb_pkg::PCS_AFTER_MLT3; // RULE_06
    assign loop_pcs_gigabit = speed_1000 && pcs_sel[0]; // RULE_07

    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = plb_pkg::HRESP_OKAY;
    assign hrdata = r.rdata;
    assign irq = |(r.irq_status & r.irq_mask);
    assign line_tx_data = r.line_tx_data;
    assign line_tx_valid = r.line_tx_valid;
    assign mac_rx_data = r.mac_rx_data;
    assign mac_rx_valid = r.mac_rx_valid;
endmodule
`default_nettype wire
